// File: rtl/edp_consts.svh
// Behaviour
// R1 - Command write drives select low, address high.
// R2 - Transfers start only on external request.
// R3 - Controller raises request when ready or data.
// R4 - Acknowledge low within 250 ns of request; the code waits unbounded while the FIFO lacks room or data.
// R5 - Handshake sustains one megabyte per second.
// R6 - Controller takes command blocks, data by DMA.
// R7 - Data flows to and from memory controller.
// R8 - Direction and address lines stable per byte.
`ifndef EDP_CONSTS_SVH
`define EDP_CONSTS_SVH
`define EDP_CLK_MHZ        40
`define EDP_ACK_MAX_NS     250
`define EDP_ACK_MAX_CYC    ((`EDP_ACK_MAX_NS * `EDP_CLK_MHZ) / 1000)
`define EDP_ACK_WIDTH_CYC  4
`define EDP_FIFO_DEPTH     8
`define EDP_DATA_W         8
`endif

// File: rtl/edp_pkg.sv
package edp_pkg;
   typedef enum logic [2:0] {
      EDP_IDLE, EDP_CMD, EDP_WAIT, EDP_ACK, EDP_REL
   } edp_state_type;
endpackage

// File: rtl/edp_fifo.sv
`timescale 1ns/10ps
module edp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   input  wire logic             clear_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             push, pop;

   assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o  = mem_reg[rd_reg];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      mem_next = mem_reg;
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      cnt_next = cnt_reg;
      if (clear_i) begin
         wr_next  = '0;
         rd_next  = '0;
         cnt_next = '0;
      end else begin
         if (push) begin
            mem_next[wr_reg] = in_data_i;
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule

// File: rtl/edp_port.sv
`timescale 1ns/10ps
`include "edp_consts.svh"
module edp_port
   import edp_pkg::*;
#(
   parameter int DW    = `EDP_DATA_W,
   parameter int DEPTH = `EDP_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic          mclk_i,
   input  wire logic          rst_n_i,
   // Host command bytes
   input  wire logic          cmd_valid_i,
   output logic               cmd_ready_o,
   input  wire logic [DW-1:0] cmd_data_i,
   // Transfer setup
   input  wire logic          xfer_en_i,
   input  wire logic          xfer_dir_out_i,
   // Memory controller, outbound
   input  wire logic          mem_out_valid_i,
   output logic               mem_out_ready_o,
   input  wire logic [DW-1:0] mem_out_data_i,
   // Memory controller, inbound
   output logic               mem_in_valid_o,
   input  wire logic          mem_in_ready_i,
   output logic      [DW-1:0] mem_in_data_o,
   // External disk port pins
   output logic               disk_port_select_n_o,
   output logic               controller_address_line_o,
   output logic               ack_n_o,
   output logic               read_write_o,
   input  wire logic          transfer_request_i,
   input  wire logic [DW-1:0] data_i,
   output logic      [DW-1:0] data_o,
   output logic               data_oe_o,
   // Status
   output logic               busy_o
);
   // A wait beyond the limit is possible: acknowledge is given in the cycle after the request
   // is seen only if the FIFO has room (inbound) or data (outbound); otherwise it waits unbounded.
   localparam int ACK_MAX = `EDP_ACK_MAX_CYC;
   localparam int ACK_W   = (`EDP_ACK_WIDTH_CYC < ACK_MAX) ?
                            `EDP_ACK_WIDTH_CYC : ACK_MAX;

   edp_state_type   st_reg, st_next;
   logic [3:0]      cnt_reg, cnt_next;
   logic [DW-1:0]   dout_reg, dout_next;
   logic            oe_reg, oe_next;
   logic            cs_reg, cs_next;
   logic            a1_reg, a1_next;
   logic            ack_reg, ack_next;
   logic            rw_reg, rw_next;
   logic            fin_valid, fin_ready;
   logic            fout_valid, fout_ready;
   logic [DW-1:0]   fout_data;
   logic [DW-1:0]   fin_data;
   logic            out_mode;
   logic            clr;

   // The FIFO direction follows the transfer setup; it is flushed when idle with transfers disabled.
   assign out_mode = xfer_dir_out_i;
   assign clr      = !xfer_en_i && (st_reg == EDP_IDLE);

   edp_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_fifo (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .clear_i     (clr),
      .in_valid_i  (fin_valid),
      .in_ready_o  (fin_ready),
      .in_data_i   (fin_data),
      .out_valid_o (fout_valid),
      .out_ready_i (fout_ready),
      .out_data_o  (fout_data)
   );

   // Memory side feeds or drains the FIFO.
   logic take_in;
   assign take_in  = (st_reg == EDP_WAIT) && transfer_request_i
                     && !out_mode;
   assign fin_valid       = out_mode ? mem_out_valid_i : take_in; // R7
   assign fin_data        = out_mode ? mem_out_data_i : data_i;
   assign mem_out_ready_o = out_mode && fin_ready;
   assign mem_in_valid_o  = !out_mode && fout_valid; // R7
   assign mem_in_data_o   = fout_data;
   logic give_out;
   assign give_out   = (st_reg == EDP_WAIT) && transfer_request_i
                       && out_mode;
   assign fout_ready = out_mode ? give_out : mem_in_ready_i;

   assign cmd_ready_o = (st_reg == EDP_IDLE);

   always_comb begin
      st_next   = st_reg;
      cnt_next  = cnt_reg;
      dout_next = dout_reg;
      oe_next   = oe_reg;
      cs_next   = cs_reg;
      a1_next   = a1_reg;
      ack_next  = ack_reg;
      rw_next   = rw_reg;
      case (st_reg)
         EDP_IDLE: begin
            ack_next = 1'b1;
            cs_next  = 1'b1;
            oe_next  = 1'b0;
            if (cmd_valid_i) begin
               cs_next   = 1'b0; // R1
               a1_next   = 1'b1; // R1
               rw_next   = 1'b0; // R8
               dout_next = cmd_data_i;
               oe_next   = 1'b1;
               cnt_next  = 4'(ACK_W);
               st_next   = EDP_CMD;
            end else if (xfer_en_i) begin
               a1_next = 1'b0; // R8
               rw_next = !out_mode; // R8
               st_next = EDP_WAIT;
            end
         end
         EDP_CMD: begin
            if (cnt_reg == 4'h1) begin
               cs_next = 1'b1;
               oe_next = 1'b0;
               st_next = EDP_IDLE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         EDP_WAIT: begin
            // Only the controller's request opens a byte.
            if (!xfer_en_i) begin
               st_next = EDP_IDLE; // R2
            end else if (transfer_request_i && (out_mode ? fout_valid
                                               : fin_ready)) begin
               ack_next = 1'b0; // R4
               if (out_mode) begin
                  dout_next = fout_data;
                  oe_next   = 1'b1;
               end
               cnt_next = 4'(ACK_W);
               st_next  = EDP_ACK;
            end
         end
         EDP_ACK: begin
            if (cnt_reg == 4'h1) begin
               ack_next = 1'b1;
               st_next  = EDP_REL;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         EDP_REL: begin
            // Wait for request to drop so one request moves one byte. R5
            oe_next = 1'b0;
            if (!transfer_request_i) begin
               st_next = EDP_WAIT;
            end
         end
         default: st_next = EDP_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg   <= EDP_IDLE;
         cnt_reg  <= 4'h0;
         dout_reg <= '0;
         oe_reg   <= 1'b0;
         cs_reg   <= 1'b1;
         a1_reg   <= 1'b0;
         ack_reg  <= 1'b1;
         rw_reg   <= 1'b1;
      end else begin
         st_reg   <= st_next;
         cnt_reg  <= cnt_next;
         dout_reg <= dout_next;
         oe_reg   <= oe_next;
         cs_reg   <= cs_next;
         a1_reg   <= a1_next;
         ack_reg  <= ack_next;
         rw_reg   <= rw_next;
      end
   end

   assign disk_port_select_n_o      = cs_reg;
   assign controller_address_line_o = a1_reg;
   assign ack_n_o                   = ack_reg;
   assign read_write_o              = rw_reg;
   assign data_o                    = dout_reg;
   assign data_oe_o                 = oe_reg;
   assign busy_o                    = (st_reg != EDP_IDLE);
endmodule

// File: verif/edp_sva.sv
`timescale 1ns/10ps
`include "edp_consts.svh"
module edp_sva (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_ready_o,
   input wire logic xfer_en_i,
   input wire logic xfer_dir_out_i,
   input wire logic mem_in_valid_o,
   input wire logic disk_port_select_n_o,
   input wire logic controller_address_line_o,
   input wire logic ack_n_o,
   input wire logic read_write_o,
   input wire logic transfer_request_i,
   input wire logic data_oe_o,
   input wire logic busy_o
);
   localparam int ACK_MAX = `EDP_ACK_MAX_CYC;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   chk_cmd_pins: assert property (cmd_valid_i && cmd_ready_o |=>
      !disk_port_select_n_o && controller_address_line_o) else $error("cmd");
   chk_sel_width: assert property ($fell(disk_port_select_n_o) |->
      (!disk_port_select_n_o)[*4] ##1 disk_port_select_n_o) else $error("sel");
   chk_busy_refuse: assert property (busy_o |-> !cmd_ready_o)
      else $error("ready while busy");
   chk_req_paced: assert property ($fell(ack_n_o) |->
      $past(transfer_request_i)) else $error("ack without request");
   // Only an empty inbound buffer guarantees room, so only then is it timed.
   chk_ack_latency: assert property ($rose(transfer_request_i) &&
      xfer_en_i && !xfer_dir_out_i && !mem_in_valid_o |->
      ##[1:ACK_MAX] !ack_n_o) else $error("ack late");
   chk_ack_width: assert property ($fell(ack_n_o) |->
      (!ack_n_o)[*4] ##1 ack_n_o) else $error("ack width");
   chk_dir_stable: assert property (!ack_n_o && !$past(ack_n_o) |->
      $stable(read_write_o) && $stable(controller_address_line_o))
      else $error("dir moved");
   chk_out_drive: assert property (!ack_n_o && !read_write_o |->
      data_oe_o) else $error("bus not driven");
   chk_in_release: assert property (!ack_n_o && read_write_o |->
      !data_oe_o) else $error("bus driven on read");
   cover property ($fell(ack_n_o) && read_write_o);
   cover property ($fell(ack_n_o) && !read_write_o);
   cover property ($fell(disk_port_select_n_o));
endmodule

// File: verif/edp_disk_model.sv
`timescale 1ns/10ps
module edp_disk_model (
   input  wire logic       mclk_i,
   input  wire logic       go_i,
   input  wire logic [7:0] tx_i,
   input  wire logic [3:0] gap_i,
   input  wire logic       ack_n_i,
   input  wire logic       sel_n_i,
   input  wire logic       oe_i,
   input  wire logic [7:0] bus_i,
   output logic            req_o = 1'b0,
   output logic [7:0]      data_o = 8'h5a,
   output logic            busy_o = 1'b0,
   output logic            got_o = 1'b0,
   output logic [7:0]      got_data_o = 8'h00
);
   logic pa = 1'b1;
   logic ps = 1'b1;
   int   n;
   always @(posedge mclk_i) begin
      if (go_i) begin
         busy_o <= 1'b1;
         repeat (gap_i + 1) @(posedge mclk_i);
         req_o  <= 1'b1;
         data_o <= tx_i;
         n = 0;
         while (ack_n_i !== 1'b0 && n < 40) begin
            @(posedge mclk_i);
            n++;
         end
         while (ack_n_i === 1'b0) @(posedge mclk_i);
         // A released bus shows the inverse so stale data never matches.
         req_o  <= 1'b0;
         data_o <= ~tx_i;
         repeat (2) @(posedge mclk_i);
         busy_o <= 1'b0;
      end
   end
   always @(posedge mclk_i) begin
      pa <= ack_n_i;
      ps <= sel_n_i;
      got_o <= oe_i === 1'b1 && ((pa && !ack_n_i) || (ps && !sel_n_i));
      got_data_o <= bus_i;
   end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, xfer_en_i = 1'b0;
   logic xfer_dir_out_i = 1'b0, mem_out_valid_i = 1'b0, mem_in_ready_i = 1'b0;
   logic [7:0] cmd_data_i = 8'h00, mem_out_data_i = 8'h00, tx = 8'h00;
   logic [7:0] data_i, data_o, mem_in_data_o, got_data, b;
   logic cmd_ready_o, mem_out_ready_o, mem_in_valid_o, disk_port_select_n_o;
   logic controller_address_line_o, ack_n_o, read_write_o, data_oe_o, busy_o;
   logic transfer_request_i, go = 1'b0, m_busy, got;
   logic [3:0] gap = 4'h0;
   logic [7:0] dq[$];
   logic [7:0] mq[$];
   int error_cnt = 0, num_checks = 0, cyc_cnt = 0;
   edp_port dut (.*);
   edp_disk_model u_disk (.mclk_i(mclk_i), .go_i(go), .tx_i(tx), .gap_i(gap),
      .ack_n_i(ack_n_o), .sel_n_i(disk_port_select_n_o), .oe_i(data_oe_o),
      .bus_i(data_o), .req_o(transfer_request_i), .data_o(data_i),
      .busy_o(m_busy), .got_o(got), .got_data_o(got_data));
   initial forever #12.5 mclk_i = ~mclk_i;
   task automatic cmp(logic [7:0] g, logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic send_cmd(logic [7:0] v);
      int n = 0;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b1;
      cmd_data_i <= v;
      dq.push_back(v);
      do @(posedge mclk_i); while (cmd_ready_o !== 1'b1 && n++ < 50);
      cmd_valid_i <= 1'b0;
   endtask
   task automatic send_mem(logic [7:0] v);
      int n = 0;
      @(posedge mclk_i);
      mem_out_valid_i <= 1'b1;
      mem_out_data_i <= v;
      dq.push_back(v);
      do @(posedge mclk_i); while (mem_out_ready_o !== 1'b1 && n++ < 50);
      mem_out_valid_i <= 1'b0;
   endtask
   task automatic go_byte(logic [7:0] v, logic [3:0] g);
      int n = 0;
      @(posedge mclk_i);
      tx <= v;
      gap <= g;
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      @(posedge mclk_i);
      while (m_busy === 1'b1 && n++ < 80) @(posedge mclk_i);
      // A partner that never finishes is a hang, so it counts as a mismatch.
      if (m_busy === 1'b1) error_cnt++;
   endtask
   // The memory side stalls at random so the inbound buffer backs up.
   always @(posedge mclk_i) mem_in_ready_i <= 1'($urandom);
   always @(posedge mclk_i) begin
      if (got === 1'b1) cmp(got_data, dq.size() ? dq.pop_front() : 8'hxx);
      if (mem_in_valid_o === 1'b1 && mem_in_ready_i)
         cmp(mem_in_data_o, mq.size() ? mq.pop_front() : 8'hxx);
   end
   always @(posedge mclk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 6000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(92));
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      cmp({3'h0, disk_port_select_n_o, controller_address_line_o, ack_n_o,
         read_write_o, data_oe_o}, 8'h16);
      repeat (3) send_cmd(8'($urandom));
      repeat (6) @(posedge mclk_i);
      xfer_dir_out_i <= 1'b1;
      xfer_en_i <= 1'b1;
      repeat (8) send_mem(8'($urandom));
      @(posedge mclk_i);
      cmp({7'h0, mem_out_ready_o}, 8'h00);
      // The ninth request finds the buffer empty and must go unanswered.
      for (int i = 0; i < 9; i++) go_byte(8'h00, 4'(i % 4));
      xfer_en_i <= 1'b0;
      @(posedge mclk_i);
      xfer_dir_out_i <= 1'b0;
      xfer_en_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         b = 8'($urandom);
         mq.push_back(b);
         go_byte(b, 4'($urandom_range(0, 6)));
      end
      repeat (30) @(posedge mclk_i);
      cmp(8'(dq.size() + mq.size()), 8'h00);
      xfer_en_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      cmp({7'h0, busy_o}, 8'h00);
      wrap_up();
   end
endmodule
bind edp_port edp_sva u_sva (.*);
